/* sound_synth_pkg.sv */
package sound_synth_pkg;

  // =========================================================
  // register map
  localparam int          REG_W         = 8;
  localparam int          ADDR_W        = 5;
  localparam int          VOICES        = 3;
  localparam logic [4:0]  VOICE_STRIDE  = 5'h07;
  localparam logic [4:0]  OFS_FREQ_LOW  = 5'h00;
  localparam logic [4:0]  OFS_FREQ_HIGH = 5'h01;
  localparam logic [4:0]  OFS_PW_LOW    = 5'h02;
  localparam logic [4:0]  OFS_PW_HIGH   = 5'h03;
  localparam logic [4:0]  OFS_CONTROL   = 5'h04;
  localparam logic [4:0]  OFS_ATK_DCY   = 5'h05;
  localparam logic [4:0]  OFS_SUS_REL   = 5'h06;
  localparam logic [4:0]  FILTER_CUTOFF_LOW        = 5'h15;
  localparam logic [4:0]  FILTER_CUTOFF_HIGH       = 5'h16;
  localparam logic [4:0]  FILTER_RESONANCE_ROUTING = 5'h17;
  localparam logic [4:0]  FILTER_MODE_VOLUME       = 5'h18;
  localparam logic [4:0]  PADDLE_X_READING         = 5'h19;
  localparam logic [4:0]  PADDLE_Y_READING         = 5'h1a;
  localparam logic [4:0]  THIRD_OSCILLATOR_READBACK = 5'h1b;
  localparam logic [4:0]  THIRD_ENVELOPE_READBACK  = 5'h1c;

  // =========================================================
  // field positions
  localparam int CTRL_GATE  = 0;
  localparam int CTRL_SYNC  = 1;
  localparam int CTRL_RING  = 2;
  localparam int CTRL_TEST  = 3;
  localparam int CTRL_TRI   = 4;
  localparam int CTRL_SAW   = 5;
  localparam int CTRL_PULSE = 6;
  localparam int CTRL_NOISE = 7;
  localparam int ROUTE_EXT  = 3;
  localparam int MODE_LP    = 4;
  localparam int MODE_BP    = 5;
  localparam int MODE_HP    = 6;
  localparam int MODE_3OFF  = 7;

  // =========================================================
  // timing
  localparam int          CLOCK_HZ     = 20_000_000;
  localparam int          ENV_STEPS    = 255;
  localparam int          DECAY_RATIO  = 3;
  localparam logic [7:0]  ENV_PEAK     = 8'hff;
  localparam int          ATTACK_US [16] = '{
    2000, 4000, 8000, 16000, 32000, 64000, 125000, 250000,
    400000, 600000, 1000000, 1500000, 2500000, 4000000,
    6000000, 8000000};
  localparam logic [22:0] NOISE_SEED   = 23'h7fffff;

  typedef struct packed {
    logic [15:0] freq;
    logic [11:0] pulse_width;
    logic [7:0]  control;
    logic [7:0]  attack_decay;
    logic [7:0]  sustain_release;
  } voice_regs_s;

  typedef struct packed {
    logic [10:0] cutoff;
    logic [7:0]  resonance_routing;
    logic [7:0]  mode_volume;
  } filter_regs_s;

  typedef enum logic [1:0] {
    ENV_ATTACK  = 2'b00,
    ENV_DECAY   = 2'b01,
    ENV_RELEASE = 2'b10
  } envelope_phases_e;

endpackage

/* three_voice_sound_synth.sv */
`timescale 1ns/1ps
module three_voice_sound_synth
  import sound_synth_pkg::*;
#(
  parameter int ACC_W      = 24,
  parameter int CLOCK_HZ_P = CLOCK_HZ,
  parameter int SAMPLE_DIV = 20,
  parameter int PADDLE_DIV = 8192
)(
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  // register port
  input  wire logic [ADDR_W-1:0]   i_address,
  input  wire logic [REG_W-1:0]    i_write_data,
  input  wire logic                i_write_strobe,
  input  wire logic                i_read_strobe,
  output logic      [REG_W-1:0]    o_read_data,
  // paddle converter results and external audio
  input  wire logic [7:0]          i_paddle_x,
  input  wire logic [7:0]          i_paddle_y,
  input  wire logic signed [13:0]  i_ext_audio,
  // mixed audio
  output logic signed [15:0]       o_audio
);

  if (ACC_W < 20 || ACC_W > 32 || SAMPLE_DIV < 1 || PADDLE_DIV < 1 ||
      SAMPLE_DIV > 65536 || PADDLE_DIV > 65536 ||
      CLOCK_HZ_P < 1000) begin : g_bad_param
    $error("three_voice_sound_synth: unsupported parameter value");
  end

  // =========================================================
  // helpers
  function automatic logic [1:0] voice_of(input logic [4:0] a);
    if (a < VOICE_STRIDE) return 2'd0;
    else if (a < 5'(2 * VOICE_STRIDE)) return 2'd1;
    else if (a < 5'(3 * VOICE_STRIDE)) return 2'd2;
    else return 2'd3;
  endfunction

  // cycles per envelope step; never below one
  function automatic logic [23:0] step_period(input int us);
    longint c;
    c = (longint'(us) * CLOCK_HZ_P) / (longint'(1_000_000) * ENV_STEPS);
    if (c < 1) c = 1;
    return 24'(c);
  endfunction

  // slows falling phases as the level drops, for an exponential curve
  function automatic logic [1:0] exp_shift(input logic [7:0] lvl);
    if (lvl[7]) return 2'd0;
    else if (lvl[6]) return 2'd1;
    else if (lvl[5]) return 2'd2;
    else return 2'd3;
  endfunction

  function automatic logic signed [19:0] sat20(input logic signed [31:0] x);
    if (x > 32'sd524287) return 20'sh7ffff;
    else if (x < -32'sd524288) return 20'sh80000;
    else return x[19:0];
  endfunction

  // =========================================================
  // register file
  voice_regs_s  voice_ff [VOICES];
  voice_regs_s  nxt_voice [VOICES];
  filter_regs_s filter_ff;
  filter_regs_s nxt_filter;
  logic [7:0]   paddle_x_ff;
  logic [7:0]   paddle_y_ff;
  logic [7:0]   nxt_paddle_x;
  logic [7:0]   nxt_paddle_y;
  logic [15:0]  paddle_cnt_ff;
  logic [15:0]  nxt_paddle_cnt;
  logic [7:0]   o_read_data_ff;
  logic [7:0]   nxt_read_data;
  logic [7:0]   env_level_ff [VOICES];
  logic [11:0]  wave [VOICES];

  always_comb begin
    logic [1:0] v;
    logic [4:0] f;
    v = voice_of(i_address);
    f = 5'd0;
    nxt_voice  = voice_ff;
    nxt_filter = filter_ff;
    nxt_read_data = 8'h00;
    nxt_paddle_x  = paddle_x_ff;
    nxt_paddle_y  = paddle_y_ff;
    nxt_paddle_cnt = paddle_cnt_ff + 16'h0001;
    // periodic latch of the converter results
    if (paddle_cnt_ff == 16'(PADDLE_DIV - 1)) begin
      nxt_paddle_cnt = 16'h0000;
      nxt_paddle_x   = i_paddle_x;
      nxt_paddle_y   = i_paddle_y;
    end
    if (v != 2'd3) f = i_address - 5'(v * VOICE_STRIDE);
    if (i_write_strobe && v != 2'd3) begin
      unique case (f)
        OFS_FREQ_LOW:  nxt_voice[v].freq[7:0]         = i_write_data;
        OFS_FREQ_HIGH: nxt_voice[v].freq[15:8]        = i_write_data;
        OFS_PW_LOW:    nxt_voice[v].pulse_width[7:0]  = i_write_data;
        OFS_PW_HIGH:   nxt_voice[v].pulse_width[11:8] = i_write_data[3:0];
        OFS_CONTROL:   nxt_voice[v].control           = i_write_data;
        OFS_ATK_DCY:   nxt_voice[v].attack_decay      = i_write_data;
        OFS_SUS_REL:   nxt_voice[v].sustain_release   = i_write_data;
        default: ;
      endcase
    end else if (i_write_strobe) begin
      unique case (i_address)
        FILTER_CUTOFF_LOW:  nxt_filter.cutoff[2:0]  = i_write_data[2:0];
        FILTER_CUTOFF_HIGH: nxt_filter.cutoff[10:3] = i_write_data;
        FILTER_RESONANCE_ROUTING: nxt_filter.resonance_routing = i_write_data;
        FILTER_MODE_VOLUME: nxt_filter.mode_volume = i_write_data;
        default: ;
      endcase
    end
    // write-only registers read back as zero
    if (i_read_strobe) begin
      unique case (i_address)
        PADDLE_X_READING:          nxt_read_data = paddle_x_ff;
        PADDLE_Y_READING:          nxt_read_data = paddle_y_ff;
        THIRD_OSCILLATOR_READBACK: nxt_read_data = wave[2][11:4];
        THIRD_ENVELOPE_READBACK:   nxt_read_data = env_level_ff[2];
        default:                   nxt_read_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < VOICES; i++) voice_ff[i] <= '0;
      filter_ff      <= '0;
      paddle_x_ff    <= 8'h00;
      paddle_y_ff    <= 8'h00;
      paddle_cnt_ff  <= 16'h0000;
      o_read_data_ff <= 8'h00;
    end else begin
      voice_ff       <= nxt_voice;
      filter_ff      <= nxt_filter;
      paddle_x_ff    <= nxt_paddle_x;
      paddle_y_ff    <= nxt_paddle_y;
      paddle_cnt_ff  <= nxt_paddle_cnt;
      o_read_data_ff <= nxt_read_data;
    end
  end

  assign o_read_data = o_read_data_ff;

  // =========================================================
  // oscillators
  logic [ACC_W-1:0] acc_ff [VOICES];
  logic [ACC_W-1:0] nxt_acc [VOICES];
  logic [22:0]      noise_ff [VOICES];
  logic [22:0]      nxt_noise [VOICES];

  always_comb begin
    logic [ACC_W-1:0] sum [VOICES];
    logic             wrap [VOICES];
    for (int i = 0; i < VOICES; i++) begin
      sum[i]  = acc_ff[i] + ACC_W'(voice_ff[i].freq);
      wrap[i] = sum[i][ACC_W-1] & ~acc_ff[i][ACC_W-1];
    end
    for (int i = 0; i < VOICES; i++) begin
      int p;
      p = (i + VOICES - 1) % VOICES;
      nxt_acc[i]   = sum[i];
      nxt_noise[i] = noise_ff[i];
      if (voice_ff[i].control[CTRL_SYNC] && wrap[p])
        nxt_acc[i] = '0;
      // noise shifts on a rising accumulator bit, so it tracks pitch
      if (sum[i][ACC_W-5] && !acc_ff[i][ACC_W-5])
        nxt_noise[i] = {noise_ff[i][21:0],
                        noise_ff[i][22] ^ noise_ff[i][17]};
      if (voice_ff[i].control[CTRL_TEST]) begin
        nxt_acc[i]   = '0;
        nxt_noise[i] = NOISE_SEED;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < VOICES; i++) begin
        acc_ff[i]   <= '0;
        noise_ff[i] <= NOISE_SEED;
      end
    end else begin
      acc_ff   <= nxt_acc;
      noise_ff <= nxt_noise;
    end
  end

  // selected waveforms combine by and, as several may be on at once
  always_comb begin
    for (int i = 0; i < VOICES; i++) begin
      logic [11:0] top;
      logic        msb;
      logic [11:0] w;
      int          p;
      p   = (i + VOICES - 1) % VOICES;
      top = acc_ff[i][ACC_W-1 -: 12];
      msb = acc_ff[i][ACC_W-1] ^ (voice_ff[i].control[CTRL_RING] &
            acc_ff[p][ACC_W-1]);
      w   = 12'hfff;
      if (voice_ff[i].control[CTRL_TRI])
        w &= {acc_ff[i][ACC_W-2 -: 11], 1'b0} ^ {12{msb}};
      if (voice_ff[i].control[CTRL_SAW]) w &= top;
      if (voice_ff[i].control[CTRL_PULSE])
        w &= (top >= voice_ff[i].pulse_width) ? 12'hfff : 12'h000;
      if (voice_ff[i].control[CTRL_NOISE])
        w &= {noise_ff[i][22:15], 4'h0};
      if (voice_ff[i].control[7:4] == 4'h0) w = 12'h000;
      wave[i] = w;
    end
  end

  // =========================================================
  // envelope generators
  envelope_phases_e env_phase_ff [VOICES];
  envelope_phases_e nxt_env_phase [VOICES];
  logic [7:0]       nxt_env_level [VOICES];
  logic [23:0]      env_cnt_ff [VOICES];
  logic [23:0]      nxt_env_cnt [VOICES];
  logic             gate_ff [VOICES];
  logic             nxt_gate [VOICES];

  always_comb begin
    for (int i = 0; i < VOICES; i++) begin
      logic       gate;
      logic [7:0] sus;
      logic [23:0] per;
      per  = 24'h000001;
      gate = voice_ff[i].control[CTRL_GATE];
      sus  = {voice_ff[i].sustain_release[7:4],
              voice_ff[i].sustain_release[7:4]};
      nxt_gate[i]      = gate;
      nxt_env_phase[i] = env_phase_ff[i];
      nxt_env_level[i] = env_level_ff[i];
      nxt_env_cnt[i]   = env_cnt_ff[i] + 24'h000001;
      unique case (env_phase_ff[i])
        ENV_ATTACK:
          per = step_period(ATTACK_US[voice_ff[i].attack_decay[7:4]]);
        ENV_DECAY:
          per = step_period(ATTACK_US[voice_ff[i].attack_decay[3:0]] *
                DECAY_RATIO) << exp_shift(env_level_ff[i]);
        ENV_RELEASE:
          per = step_period(ATTACK_US[voice_ff[i].sustain_release[3:0]] *
                DECAY_RATIO) << exp_shift(env_level_ff[i]);
      endcase
      if (env_cnt_ff[i] >= per - 24'h000001) begin
        nxt_env_cnt[i] = 24'h000000;
        unique case (env_phase_ff[i])
          ENV_ATTACK: begin
            if (env_level_ff[i] == ENV_PEAK) nxt_env_phase[i] = ENV_DECAY;
            else nxt_env_level[i] = env_level_ff[i] + 8'h01;
          end
          ENV_DECAY: begin
            if (env_level_ff[i] > sus)
              nxt_env_level[i] = env_level_ff[i] - 8'h01;
          end
          ENV_RELEASE: begin
            if (env_level_ff[i] != 8'h00)
              nxt_env_level[i] = env_level_ff[i] - 8'h01;
          end
        endcase
      end
      if (gate && !gate_ff[i]) begin
        nxt_env_phase[i] = ENV_ATTACK;
        nxt_env_cnt[i]   = 24'h000000;
      end else if (!gate && gate_ff[i]) begin
        nxt_env_phase[i] = ENV_RELEASE;
        nxt_env_cnt[i]   = 24'h000000;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < VOICES; i++) begin
        env_phase_ff[i] <= ENV_RELEASE;
        env_level_ff[i] <= 8'h00;
        env_cnt_ff[i]   <= 24'h000000;
        gate_ff[i]      <= 1'b0;
      end
    end else begin
      env_phase_ff <= nxt_env_phase;
      env_level_ff <= nxt_env_level;
      env_cnt_ff   <= nxt_env_cnt;
      gate_ff      <= nxt_gate;
    end
  end

  // =========================================================
  // amplitude modulators, filter and mixer
  logic signed [13:0] voice_amp [VOICES];
  logic [15:0]        sample_cnt_ff;
  logic [15:0]        nxt_sample_cnt;
  logic signed [19:0] low_ff;
  logic signed [19:0] band_ff;
  logic signed [19:0] nxt_low;
  logic signed [19:0] nxt_band;
  logic signed [15:0] o_audio_ff;
  logic signed [15:0] nxt_audio;

  always_comb begin
    for (int i = 0; i < VOICES; i++) begin
      logic signed [31:0] prod;
      prod = (32'(signed'({1'b0, wave[i]})) - 32'sd2048) *
             32'(signed'({1'b0, env_level_ff[i]}));
      voice_amp[i] = prod[21:8];
    end
  end

  // state-variable filter updated at the sample rate only
  always_comb begin
    logic signed [31:0] to_filt;
    logic signed [31:0] direct;
    logic signed [31:0] high;
    logic signed [31:0] coef;
    logic signed [31:0] damp;
    logic signed [31:0] mix;
    logic [7:0]         route;
    mix     = 32'sd0;
    route   = filter_ff.resonance_routing;
    to_filt = 32'sd0;
    direct  = 32'sd0;
    for (int i = 0; i < VOICES; i++) begin
      if (route[i]) to_filt += 32'(voice_amp[i]);
      else if (!(i == VOICES - 1 && filter_ff.mode_volume[MODE_3OFF]))
        direct += 32'(voice_amp[i]);
    end
    if (route[ROUTE_EXT]) to_filt += 32'(i_ext_audio);
    else direct += 32'(i_ext_audio);
    coef = 32'(filter_ff.cutoff[10:4]) + 32'sd1;
    damp = 32'sd16 - 32'(route[7:4]);
    high = to_filt - 32'(low_ff) - ((32'(band_ff) * damp) >>> 3);
    nxt_sample_cnt = sample_cnt_ff + 16'h0001;
    nxt_band  = band_ff;
    nxt_low   = low_ff;
    nxt_audio = o_audio_ff;
    if (sample_cnt_ff == 16'(SAMPLE_DIV - 1)) begin
      nxt_sample_cnt = 16'h0000;
      nxt_band = sat20(32'(band_ff) + ((high * coef) >>> 8));
      nxt_low  = sat20(32'(low_ff) + ((32'(band_ff) * coef) >>> 8));
      mix = direct;
      if (filter_ff.mode_volume[MODE_LP]) mix += 32'(low_ff);
      if (filter_ff.mode_volume[MODE_BP]) mix += 32'(band_ff);
      if (filter_ff.mode_volume[MODE_HP]) mix += high;
      mix = (mix * 32'(signed'({1'b0, filter_ff.mode_volume[3:0]}))) >>> 4;
      if (mix > 32'sd32767) nxt_audio = 16'sh7fff;
      else if (mix < -32'sd32768) nxt_audio = 16'sh8000;
      else nxt_audio = mix[15:0];
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sample_cnt_ff <= 16'h0000;
      band_ff       <= 20'sh00000;
      low_ff        <= 20'sh00000;
      o_audio_ff    <= 16'sh0000;
    end else begin
      sample_cnt_ff <= nxt_sample_cnt;
      band_ff       <= nxt_band;
      low_ff        <= nxt_low;
      o_audio_ff    <= nxt_audio;
    end
  end

  assign o_audio = o_audio_ff;

endmodule

/* three_voice_sound_synth_asserts.sv */
`timescale 1ns/1ps
module three_voice_sound_synth_asserts
  import sound_synth_pkg::*;
#(
  parameter int SAMPLE_DIV = 20,
  parameter int PADDLE_DIV = 8192
)(
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  // register port
  input  wire logic [ADDR_W-1:0]   i_address,
  input  wire logic [REG_W-1:0]    i_write_data,
  input  wire logic                i_write_strobe,
  input  wire logic                i_read_strobe,
  input  wire logic [REG_W-1:0]    o_read_data,
  // paddles and audio
  input  wire logic [7:0]          i_paddle_x,
  input  wire logic [7:0]          i_paddle_y,
  input  wire logic signed [15:0]  o_audio
);
  // =========================================================
  // helper state
  localparam logic [4:0] CTRL3 = 5'h12;
  logic [7:0]         ctrl3_ff;
  logic [1:0]         age3_ff;
  logic               gated3_ff;
  logic [7:0]         px_last_ff;
  logic [7:0]         py_last_ff;
  int                 px_age_ff;
  int                 py_age_ff;
  int                 aud_age_ff;
  logic signed [15:0] aud_last_ff;

  // ages saturate so long idle stretches never wrap
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ctrl3_ff    <= 8'h00;
      age3_ff     <= 2'h0;
      gated3_ff   <= 1'b0;
      px_last_ff  <= 8'h00;
      py_last_ff  <= 8'h00;
      px_age_ff   <= 0;
      py_age_ff   <= 0;
      aud_age_ff  <= SAMPLE_DIV;
      aud_last_ff <= 16'sh0000;
    end else begin
      if (i_write_strobe && i_address == CTRL3) begin
        ctrl3_ff  <= i_write_data;
        age3_ff   <= 2'h0;
        gated3_ff <= gated3_ff | i_write_data[CTRL_GATE];
      end else if (age3_ff != 2'h3) begin
        age3_ff <= age3_ff + 2'h1;
      end
      px_last_ff  <= i_paddle_x;
      py_last_ff  <= i_paddle_y;
      px_age_ff   <= (i_paddle_x != px_last_ff) ? 0 :
                     px_age_ff + int'(px_age_ff < 100000);
      py_age_ff   <= (i_paddle_y != py_last_ff) ? 0 :
                     py_age_ff + int'(py_age_ff < 100000);
      aud_last_ff <= o_audio;
      aud_age_ff  <= (o_audio != aud_last_ff) ? 1 :
                     aud_age_ff + int'(aud_age_ff < 100000);
    end
  end

  // =========================================================
  // properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_read_idle_zero: assert property (
    !i_read_strobe |=> o_read_data == 8'h00)
    else $error("read data not zero outside a read");
  a_wo_read_zero: assert property (
    i_read_strobe && i_address <= FILTER_MODE_VOLUME |=> o_read_data == 8'h00)
    else $error("write-only register read back nonzero");
  a_unmapped_zero: assert property (
    i_read_strobe && i_address > THIRD_ENVELOPE_READBACK
    |=> o_read_data == 8'h00)
    else $error("unmapped address read back nonzero");
  a_paddle_x_read: assert property (
    i_read_strobe && i_address == PADDLE_X_READING &&
    px_age_ff >= PADDLE_DIV + 3 |=> o_read_data == $past(i_paddle_x))
    else $error("paddle x reading wrong");
  a_paddle_y_read: assert property (
    i_read_strobe && i_address == PADDLE_Y_READING &&
    py_age_ff >= PADDLE_DIV + 3 |=> o_read_data == $past(i_paddle_y))
    else $error("paddle y reading wrong");
  a_third_envelope_readback_quiet: assert property (
    i_read_strobe && i_address == THIRD_ENVELOPE_READBACK && !gated3_ff
    |=> o_read_data == 8'h00)
    else $error("third envelope moved without a gate");
  a_osc3_held: assert property (
    i_read_strobe && i_address == THIRD_OSCILLATOR_READBACK &&
    !ctrl3_ff[CTRL_RING] && (ctrl3_ff[7:4] == 4'h0 ||
    (ctrl3_ff[CTRL_TEST] && ctrl3_ff[7:6] == 2'b00 && age3_ff == 2'h3))
    |=> o_read_data == 8'h00)
    else $error("third oscillator output nonzero while held");
  a_audio_spacing: assert property (
    o_audio != aud_last_ff |-> aud_age_ff >= SAMPLE_DIV)
    else $error("audio output changed between sample ticks");

  c_env_read: cover property (
    i_read_strobe && i_address == THIRD_ENVELOPE_READBACK
    ##1 o_read_data != 8'h00);
  c_paddle_read: cover property (
    i_read_strobe && i_address == PADDLE_X_READING && px_age_ff > PADDLE_DIV);
  c_audio_moves: cover property (o_audio != aud_last_ff);
endmodule

/* host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model
  import sound_synth_pkg::*;
(
  // clock
  input  wire logic               i_clock,
  // register port towards the synth
  output logic [ADDR_W-1:0]       o_address,
  output logic [REG_W-1:0]        o_write_data,
  output logic                    o_write_strobe,
  output logic                    o_read_strobe,
  input  wire logic [REG_W-1:0]   i_read_data
);
  initial begin
    o_address      = 5'h00;
    o_write_data   = 8'h00;
    o_write_strobe = 1'b0;
    o_read_strobe  = 1'b0;
  end

  // =========================================================
  // bus cycles
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_address      <= a;
    o_write_data   <= d;
    o_write_strobe <= 1'b1;
    @(posedge i_clock);
    o_write_strobe <= 1'b0;
    // stale data is scrambled so nothing relies on it lingering
    o_write_data   <= ~d;
  endtask

  task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_address     <= a;
    o_read_strobe <= 1'b1;
    @(posedge i_clock);
    o_read_strobe <= 1'b0;
    #1;
    d = i_read_data;
  endtask

  // envelope set before the waveform so the note starts on known rates
  task automatic play(input int v, input logic [7:0] ad,
                      input logic [7:0] sr, input logic [7:0] ctrl);
    logic [4:0] base;
    base = 5'(v) * VOICE_STRIDE;
    write_reg(base + OFS_ATK_DCY, ad);
    write_reg(base + OFS_SUS_REL, sr);
    write_reg(base + OFS_CONTROL, ctrl);
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import sound_synth_pkg::*;
  localparam int CK = 1000;
  logic                i_clock;
  logic                i_reset;
  logic [ADDR_W-1:0]   address;
  logic [REG_W-1:0]    write_data;
  logic                write_strobe;
  logic                read_strobe;
  logic [REG_W-1:0]    read_data;
  logic [7:0]          paddle_x;
  logic [7:0]          paddle_y;
  logic signed [13:0]  ext_audio;
  logic signed [15:0]  audio;
  int                  num_errors = 0;
  int                  cmp_count = 0;

  three_voice_sound_synth #(
    .ACC_W(24), .CLOCK_HZ_P(CK), .SAMPLE_DIV(2), .PADDLE_DIV(4)
  ) u_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_address(address),
    .i_write_data(write_data), .i_write_strobe(write_strobe),
    .i_read_strobe(read_strobe), .o_read_data(read_data),
    .i_paddle_x(paddle_x), .i_paddle_y(paddle_y),
    .i_ext_audio(ext_audio), .o_audio(audio));

  host_bus_model u_host (
    .i_clock(i_clock), .o_address(address), .o_write_data(write_data),
    .o_write_strobe(write_strobe), .o_read_strobe(read_strobe),
    .i_read_data(read_data));

  // =========================================================
  // checking and verdict
  task automatic check_eq(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_true(input string what, input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %s expected 1 seen %b", what, ok);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  initial begin
    repeat (40000) @(posedge i_clock);
    num_errors++;
    stop_test();
  end

  // =========================================================
  // scenarios
  initial begin
    logic [7:0] d;
    logic [7:0] d2;
    logic [7:0] p0;
    logic signed [15:0] a0;
    int step;
    int chg;
    logic seen;
    i_reset = 1'b1;
    paddle_x = 8'h00;
    paddle_y = 8'h00;
    ext_audio = 14'sh0000;
    step = int'(longint'(ATTACK_US[15]) * CK / (64'd1000000 * ENV_STEPS));
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int a = 0; a < 32; a++) begin
      if (a < 25 || a > 28) begin
        u_host.read_reg(a[4:0], d);
        check_eq("write-only or unmapped", 8'h00, d);
      end
    end
    paddle_x <= 8'h5a;
    paddle_y <= 8'ha5;
    repeat (12) @(posedge i_clock);
    // a write to a read-only place must not disturb it
    u_host.write_reg(PADDLE_X_READING, 8'h33);
    u_host.read_reg(PADDLE_X_READING, d);
    check_eq("paddle x", 8'h5a, d);
    u_host.read_reg(PADDLE_Y_READING, d);
    check_eq("paddle y", 8'ha5, d);
    u_host.play(2, 8'h00, 8'h80, 8'h11);
    repeat (700) @(posedge i_clock);
    u_host.read_reg(THIRD_ENVELOPE_READBACK, d);
    check_eq("sustain level", 8'h88, d);
    u_host.write_reg(5'h12, 8'h10);
    repeat (20) @(posedge i_clock);
    u_host.read_reg(THIRD_ENVELOPE_READBACK, d);
    check_true("release under way", d < 8'h88 && d > 8'h00);
    repeat (2000) @(posedge i_clock);
    u_host.read_reg(THIRD_ENVELOPE_READBACK, d);
    check_eq("released", 8'h00, d);
    u_host.play(2, 8'hf0, 8'hf0, 8'h11);
    repeat (10 * step) @(posedge i_clock);
    u_host.read_reg(THIRD_ENVELOPE_READBACK, d);
    check_true("slowest attack", d >= 8'd8 && d <= 8'd11);
    // gate dropped mid-attack: release starts from the current level
    u_host.write_reg(5'h12, 8'h10);
    repeat (300) @(posedge i_clock);
    u_host.read_reg(THIRD_ENVELOPE_READBACK, d);
    check_eq("release from attack", 8'h00, d);
    u_host.write_reg(5'h0e, 8'h00);
    u_host.write_reg(5'h0f, 8'h10);
    u_host.write_reg(5'h12, 8'h20);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, d);
    repeat (158) @(posedge i_clock);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, d2);
    check_eq("saw advance", d + 8'd10, d2);
    u_host.write_reg(5'h12, 8'h28);
    repeat (3) @(posedge i_clock);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, d);
    check_eq("test holds", 8'h00, d);
    u_host.write_reg(5'h0f, 8'h00);
    u_host.write_reg(5'h12, 8'h48);
    u_host.write_reg(5'h12, 8'h40);
    u_host.write_reg(5'h10, 8'h00);
    u_host.write_reg(5'h11, 8'h00);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, p0);
    u_host.write_reg(5'h10, 8'hff);
    u_host.write_reg(5'h11, 8'h0f);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, d);
    check_true("pulse width", p0 !== d);
    u_host.write_reg(5'h0f, 8'h10);
    u_host.write_reg(5'h12, 8'h20);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, d);
    repeat (158) @(posedge i_clock);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, d2);
    check_eq("saw ignores width", d + 8'd10, d2);
    u_host.write_reg(5'h0e, 8'hff);
    u_host.write_reg(5'h0f, 8'hff);
    u_host.write_reg(5'h12, 8'h80);
    u_host.read_reg(THIRD_OSCILLATOR_READBACK, d);
    chg = 0;
    for (int i = 0; i < 4; i++) begin
      repeat (160) @(posedge i_clock);
      u_host.read_reg(THIRD_OSCILLATOR_READBACK, d2);
      chg += int'(d2 !== d);
      d = d2;
    end
    check_true("noise varies", chg >= 2);
    u_host.write_reg(FILTER_MODE_VOLUME, 8'h0f);
    u_host.write_reg(5'h01, 8'h10);
    u_host.play(0, 8'h00, 8'hf0, 8'h11);
    seen = 1'b0;
    for (int i = 0; i < 500; i++) begin
      @(posedge i_clock);
      seen |= (audio !== 16'sh0000);
    end
    check_true("voice audible", seen);
    u_host.write_reg(5'h04, 8'h10);
    repeat (1500) @(posedge i_clock);
    a0 = audio;
    ext_audio <= 14'sh1000;
    repeat (50) @(posedge i_clock);
    check_true("external audio", audio !== a0);
    u_host.write_reg(FILTER_RESONANCE_ROUTING, 8'h08);
    repeat (4) @(posedge i_clock);
    check_true("filter path muted", audio === 16'sh0000);
    u_host.write_reg(FILTER_MODE_VOLUME, 8'h1f);
    repeat (100) @(posedge i_clock);
    check_true("low-pass output", audio !== 16'sh0000);
    stop_test();
  end
endmodule

bind three_voice_sound_synth three_voice_sound_synth_asserts #(
  .SAMPLE_DIV(SAMPLE_DIV),
  .PADDLE_DIV(PADDLE_DIV)
) u_asserts (
  .i_clock(i_clock), .i_reset(i_reset), .i_address(i_address),
  .i_write_data(i_write_data), .i_write_strobe(i_write_strobe),
  .i_read_strobe(i_read_strobe), .o_read_data(o_read_data),
  .i_paddle_x(i_paddle_x), .i_paddle_y(i_paddle_y), .o_audio(o_audio));
